// file: rtl/dmhi_consts.svh
// Offsets, field positions, reset values, command codes and timing figures of the display host port
`ifndef DMHI_CONSTS_SVH
`define DMHI_CONSTS_SVH
// Register byte offsets
`define DMHI_OFF_CTRL 12'h000
`define DMHI_OFF_STAT 12'h004
`define DMHI_OFF_TX 12'h008
// Control fields and reset value
`define DMHI_CTRL_PAR_EN 0
`define DMHI_CTRL_SER_EN 1
`define DMHI_CTRL_RST 2'h3
// Status fields
`define DMHI_ST_BRIGHT_LO 8
`define DMHI_ST_WIDTH4 10
`define DMHI_ST_GFX 11
`define DMHI_ST_CURS_EN 12
`define DMHI_ST_SRC_PAR 13
`define DMHI_ST_SRC_SER 14
`define DMHI_ST_TX_BUSY 15
// Timing figures and clock rate
`define DMHI_CLK_MHZ 10
`define DMHI_T_TXT_US 40
`define DMHI_T_GFX_US 250
`define DMHI_T_CMD_US 40
`define DMHI_T_POR_MS 8
`define DMHI_T_HWR_MS 3
// Command and data codes
`define DMHI_CMD_CLEAR 8'h01
`define DMHI_CMD_W4 8'h20
`define DMHI_CMD_W8 8'h30
`define DMHI_CMD_SETDD 8'h80
`define DMHI_CMD_GFX_LO 8'hF0
`define DMHI_CMD_GFX_HI 8'hF2
`define DMHI_PREFIX 8'h0F
`define DMHI_GLYPH_LIM 8'h10
`define DMHI_EXT_BASE 7'h70
`define DMHI_CURS_HOME 7'h00
`define DMHI_BRIGHT_FULL 2'h0
`endif

// file: rtl/dmhi_pkg.sv
// Types shared by the display host port modules
package dmhi_pkg;
  // Top-level sequencing
  typedef enum logic [0:0] {DMHI_START, DMHI_RUN} dmhi_state_t;
  // Where an accepted byte goes on the display side
  typedef enum logic [2:0] {DMHI_K_CMD, DMHI_K_TEXT, DMHI_K_GLYPH, DMHI_K_GFX, DMHI_K_EXT} dmhi_kind_t;
  // One byte handed to the display engine
  typedef struct packed {
    logic valid;
    dmhi_kind_t kind;
    logic [7:0] data;
    logic [6:0] addr;
  } dmhi_disp_t;
  // One byte assembled by a host input
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } dmhi_byte_t;
endpackage : dmhi_pkg

// file: rtl/dmhi_ser_rx.sv
// Synchronous serial receiver: MSB-first shift on the rising shift clock, framed by select
`timescale 1ns/1ps
module dmhi_ser_rx (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic serial_shift_clock,
  input wire logic serial_data_in,
  input wire logic serial_select_n,
  output dmhi_pkg::dmhi_byte_t rx
);
  logic sclk_q;
  logic [2:0] bit_cnt;
  logic [6:0] shift;
  logic rise;

  assign rise = serial_shift_clock & ~sclk_q;

  // Edge history of the shift clock
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= serial_shift_clock;
    end
  end

  // Bit counter and shifter; deselect realigns to a byte boundary
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt <= 3'h0;
      shift <= 7'h00;
      rx <= '0;
    end else begin
      rx.valid <= 1'b0;
      if (serial_select_n || !enable) begin
        bit_cnt <= 3'h0;
      end else if (rise) begin
        shift <= {shift[5:0], serial_data_in};
        bit_cnt <= bit_cnt + 3'h1;
        if (bit_cnt == 3'h7) begin
          rx.valid <= 1'b1;
          rx.data <= {shift, serial_data_in};
        end
      end
    end
  end
endmodule : dmhi_ser_rx

// file: rtl/dmhi_top.sv
// Host port of the display module: parallel and serial inputs, busy, status, APB registers
//
// Overview of operation
// - Busy rises on acceptance, falls when ready
// - Status read: busy on D7, cursor D0-D6
// - Latch on strobe fall; select picks data/command
// - Four-bit mode: upper lines, high nibble first
// - No busy between the two nibbles
// - First input to deliver a byte wins
// - Asynchronous serial strap: auto init, cursor on
// - No transmit while host holds
// - Serial bits sampled on rising clock, MSB first
// - Module busy line driven while processing
// - Serial bits only while selected; select realigns
// - Prefix 0FH makes next serial byte a command
// - Power-on internal reset lasts 8ms
// - Hardware reset then 3ms re-initialisation
// - Reset defaults: 8-bit, cleared, cursor 00H, full brightness
// - Text addresses 70H+ go to extended handling
// - Codes 00H-0FH place one of eight glyphs
// - Data busy 40us text, 250us graphic
// - After F0H-F2H data goes straight to display
// - 20H/30H width, then brightness data byte
`timescale 1ns/1ps
`include "dmhi_consts.svh"
module dmhi_top #(
  parameter int POR_CYC = `DMHI_T_POR_MS * 1000 * `DMHI_CLK_MHZ,
  parameter int HWR_CYC = `DMHI_T_HWR_MS * 1000 * `DMHI_CLK_MHZ
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic por_event,
  input wire logic async_serial_sel,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic bus_strobe,
  input wire logic read_write_select,
  input wire logic reg_select_line,
  input wire logic [7:0] parallel_data_in,
  output logic [7:0] parallel_data_out,
  output logic parallel_data_oe_n,
  output logic busy_out,
  input wire logic serial_shift_clock,
  input wire logic serial_data_in,
  input wire logic serial_select_n,
  input wire logic host_hold_line,
  output logic serial_data_out,
  output logic module_busy_line,
  output dmhi_pkg::dmhi_disp_t disp
);
  localparam int TXT_CYC = `DMHI_T_TXT_US * `DMHI_CLK_MHZ;
  localparam int GFX_CYC = `DMHI_T_GFX_US * `DMHI_CLK_MHZ;
  localparam int CMD_CYC = `DMHI_T_CMD_US * `DMHI_CLK_MHZ;

  ////////////////////////////////////////////////////////////////////////////////
  // Reset release and state
  logic rst_q1;
  logic rst_n;
  dmhi_pkg::dmhi_state_t state;
  logic [17:0] busy_cnt;
  logic busy;
  logic [1:0] ctrl;
  logic src_par;
  logic src_ser;
  logic width4;
  logic nib_hi;
  logic [3:0] hi_nib;
  logic gfx_mode;
  logic expect_lum;
  logic prefix_pend;
  logic cursor_en;
  logic [6:0] cursor;
  logic [1:0] bright;
  logic strobe_q;
  logic rs_q;
  logic rw_q;
  logic [7:0] data_q;
  logic sclk_q;
  logic [7:0] tx_shift;
  logic [3:0] tx_cnt;
  dmhi_pkg::dmhi_byte_t ser_rx;
  logic par_ok;
  logic ser_ok;
  logic par_wr;
  logic par_fire;
  logic ser_fire;
  logic acc;
  logic acc_cmd;
  logic [7:0] acc_byte;
  logic prefix_hit;
  logic txt_data;
  logic gfx_data;
  logic wcmd;
  logic apb_acc;
  logic apb_wr;
  logic tx_edge;

  // Two-flop release of the asynchronous reset
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rst_q1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n <= rst_q1;
    end
  end

  // Register decode, shared by read and write
  function automatic logic reg_hit(input logic [11:0] a);
    reg_hit = (a == `DMHI_OFF_CTRL) || (a == `DMHI_OFF_STAT) || (a == `DMHI_OFF_TX);
  endfunction : reg_hit

  ////////////////////////////////////////////////////////////////////////////////
  // Byte acceptance from either input
  assign par_ok = ctrl[`DMHI_CTRL_PAR_EN] & ~src_ser & (state == dmhi_pkg::DMHI_RUN);
  assign ser_ok = ctrl[`DMHI_CTRL_SER_EN] & ~src_par & (state == dmhi_pkg::DMHI_RUN);
  assign par_wr = strobe_q & ~bus_strobe & ~rw_q & par_ok & ~busy;
  assign par_fire = par_wr & (~width4 | ~nib_hi);
  assign ser_fire = ser_rx.valid & ser_ok & ~busy & ~par_fire;
  assign acc = par_fire | ser_fire;
  assign acc_byte = par_fire ? (width4 ? {hi_nib, data_q[7:4]} : data_q) : ser_rx.data;
  assign acc_cmd = par_fire ? ~rs_q : prefix_pend;
  assign prefix_hit = ser_fire & ~prefix_pend & (ser_rx.data == `DMHI_PREFIX);
  assign txt_data = acc & ~acc_cmd & ~prefix_hit & ~expect_lum & ~gfx_mode;
  assign gfx_data = acc & ~acc_cmd & ~prefix_hit & ~expect_lum & gfx_mode;
  assign wcmd = acc & acc_cmd & ((acc_byte == `DMHI_CMD_W4) || (acc_byte == `DMHI_CMD_W8));
  assign apb_acc = psel & penable & ~pready;
  assign apb_wr = psel & penable & pready & pwrite;
  assign tx_edge = sclk_q & ~serial_shift_clock & ~serial_select_n;

  // Serial receiver
  dmhi_ser_rx u_rx (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .enable(ser_ok),
    .serial_shift_clock(serial_shift_clock),
    .serial_data_in(serial_data_in),
    .serial_select_n(serial_select_n),
    .rx(ser_rx)
  );

  // Previous-cycle copy of the parallel lines, so the strobe-high values are latched
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      strobe_q <= 1'b0;
      rs_q <= 1'b0;
      rw_q <= 1'b0;
      data_q <= 8'h00;
      sclk_q <= 1'b0;
    end else begin
      strobe_q <= bus_strobe;
      rs_q <= reg_select_line;
      rw_q <= read_write_select;
      data_q <= parallel_data_in;
      sclk_q <= serial_shift_clock;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Start-up sequencing and busy timer
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= dmhi_pkg::DMHI_START;
      busy_cnt <= 18'h0_0000;
      busy <= 1'b1;
    end else if (state == dmhi_pkg::DMHI_START) begin
      state <= dmhi_pkg::DMHI_RUN;
      busy_cnt <= por_event ? 18'(POR_CYC) : 18'(HWR_CYC);
      busy <= 1'b1;
    end else if (acc & ~prefix_hit) begin
      busy <= 1'b1;
      if (gfx_data) begin
        busy_cnt <= 18'(GFX_CYC);
      end else if (txt_data) begin
        busy_cnt <= 18'(TXT_CYC);
      end else begin
        busy_cnt <= 18'(CMD_CYC);
      end
    end else if (busy_cnt > 18'h0_0001) begin
      busy_cnt <= busy_cnt - 18'h0_0001;
    end else begin
      busy_cnt <= 18'h0_0000;
      busy <= 1'b0;
    end
  end

  // Input commitment: whichever input delivers the first byte keeps the port
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      src_par <= 1'b0;
      src_ser <= 1'b0;
    end else if (!src_par && !src_ser) begin
      src_par <= par_fire;
      src_ser <= ser_fire;
    end
  end

  // Nibble tracking for the four-bit bus
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      nib_hi <= 1'b1;
      hi_nib <= 4'h0;
    end else if (wcmd) begin
      nib_hi <= 1'b1;
    end else if (par_wr && width4) begin
      nib_hi <= ~nib_hi;
      if (nib_hi) begin
        hi_nib <= data_q[7:4];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Mode, cursor and brightness state; byte classification
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      width4 <= 1'b0;
      gfx_mode <= 1'b0;
      expect_lum <= 1'b0;
      prefix_pend <= 1'b0;
      cursor_en <= 1'b0;
      cursor <= `DMHI_CURS_HOME;
      bright <= `DMHI_BRIGHT_FULL;
    end else if (state == dmhi_pkg::DMHI_START) begin
      cursor_en <= async_serial_sel;
    end else if (prefix_hit) begin
      prefix_pend <= 1'b1;
    end else if (acc) begin
      if (ser_fire) begin
        prefix_pend <= 1'b0;
      end
      if (acc_cmd) begin
        expect_lum <= wcmd;
        gfx_mode <= (acc_byte >= `DMHI_CMD_GFX_LO) && (acc_byte <= `DMHI_CMD_GFX_HI);
        if (wcmd) begin
          width4 <= (acc_byte == `DMHI_CMD_W4);
        end
        if (acc_byte >= `DMHI_CMD_SETDD && acc_byte < `DMHI_CMD_GFX_LO) begin
          cursor <= acc_byte[6:0];
        end else if (acc_byte == `DMHI_CMD_CLEAR) begin
          cursor <= `DMHI_CURS_HOME;
        end
        if (acc_byte < `DMHI_CMD_GFX_LO) begin
          cursor_en <= 1'b1;
        end else begin
          cursor_en <= 1'b0;
        end
      end else if (expect_lum) begin
        bright <= acc_byte[1:0];
        expect_lum <= 1'b0;
      end else if (!gfx_mode) begin
        cursor <= cursor + 7'h01;
      end
    end
  end

  // Hand each accepted byte to the display engine, except a serial prefix byte or a brightness data byte
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      disp <= '0;
    end else begin
      disp.valid <= acc & ~prefix_hit & ~(expect_lum & ~acc_cmd);
      disp.data <= acc_byte;
      disp.addr <= cursor;
      if (acc_cmd) begin
        disp.kind <= dmhi_pkg::DMHI_K_CMD;
      end else if (gfx_mode) begin
        disp.kind <= dmhi_pkg::DMHI_K_GFX;
      end else if (cursor >= `DMHI_EXT_BASE) begin
        disp.kind <= dmhi_pkg::DMHI_K_EXT;
      end else if (acc_byte < `DMHI_GLYPH_LIM) begin
        disp.kind <= dmhi_pkg::DMHI_K_GLYPH;
        disp.data <= {5'h00, acc_byte[2:0]};
      end else begin
        disp.kind <= dmhi_pkg::DMHI_K_TEXT;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Parallel read drive and busy pins
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      parallel_data_out <= 8'h00;
      parallel_data_oe_n <= 1'b1;
      busy_out <= 1'b1;
      module_busy_line <= 1'b1;
    end else begin
      busy_out <= busy;
      module_busy_line <= busy;
      parallel_data_oe_n <= ~(bus_strobe & read_write_select & par_ok);
      parallel_data_out <= reg_select_line ? 8'h00 : {busy, cursor};
    end
  end

  // Serial transmit toward the host, paused while the host holds
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_shift <= 8'h00;
      tx_cnt <= 4'h0;
      serial_data_out <= 1'b1;
    end else if (apb_wr && paddr == `DMHI_OFF_TX && tx_cnt == 4'h0) begin
      tx_shift <= pwdata[7:0];
      tx_cnt <= 4'h8;
    end else if (tx_edge && !host_hold_line && tx_cnt != 4'h0) begin
      serial_data_out <= tx_shift[7];
      tx_shift <= {tx_shift[6:0], 1'b0};
      tx_cnt <= tx_cnt - 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // APB slave: one wait state, error on unmapped address
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= apb_acc;
      pslverr <= apb_acc & ~reg_hit(paddr);
      prdata <= 32'h0000_0000;
      if (apb_acc && !pwrite && paddr == `DMHI_OFF_CTRL) begin
        prdata[1:0] <= ctrl;
      end else if (apb_acc && !pwrite && paddr == `DMHI_OFF_STAT) begin
        prdata[7:0] <= {busy, cursor};
        prdata[`DMHI_ST_BRIGHT_LO +: 2] <= bright;
        prdata[`DMHI_ST_WIDTH4] <= width4;
        prdata[`DMHI_ST_GFX] <= gfx_mode;
        prdata[`DMHI_ST_CURS_EN] <= cursor_en;
        prdata[`DMHI_ST_SRC_PAR] <= src_par;
        prdata[`DMHI_ST_SRC_SER] <= src_ser;
        prdata[`DMHI_ST_TX_BUSY] <= (tx_cnt != 4'h0);
      end
    end
  end

  // Control register write
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= `DMHI_CTRL_RST;
    end else if (apb_wr && paddr == `DMHI_OFF_CTRL) begin
      ctrl <= pwdata[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_busy_on_accept;
    @(posedge core_clk) disable iff (!rst_n) (acc && !prefix_hit && state == dmhi_pkg::DMHI_RUN) |=> busy;
  endproperty
  a_busy_on_accept: assert property (p_busy_on_accept) else $error("busy not raised after byte");

  property p_text_busy;
    @(posedge core_clk) disable iff (!rst_n) txt_data |=> busy_cnt == 18'(TXT_CYC);
  endproperty
  a_text_busy: assert property (p_text_busy) else $error("text busy time wrong");

  property p_gfx_busy;
    @(posedge core_clk) disable iff (!rst_n) gfx_data |=> (busy_cnt == 18'(GFX_CYC)) ##1 busy[*8];
  endproperty
  a_gfx_busy: assert property (p_gfx_busy) else $error("graphic busy time wrong");

  property p_no_nibble_busy;
    @(posedge core_clk) disable iff (!rst_n) (par_wr && width4 && nib_hi && !busy) |=> !busy && !disp.valid;
  endproperty
  a_no_nibble_busy: assert property (p_no_nibble_busy) else $error("busy after first nibble");

  property p_prefix_swallow;
    @(posedge core_clk) disable iff (!rst_n) prefix_hit |=> $stable(cursor) && !disp.valid && prefix_pend;
  endproperty
  a_prefix_swallow: assert property (p_prefix_swallow) else $error("prefix byte leaked");

  property p_commit;
    @(posedge core_clk) disable iff (!rst_n) (src_par || src_ser) |=> $stable(src_par) && $stable(src_ser);
  endproperty
  a_commit: assert property (p_commit) else $error("input commitment changed");

  property p_hold;
    @(posedge core_clk) disable iff (!rst_n) host_hold_line |=> $stable(serial_data_out);
  endproperty
  a_hold: assert property (p_hold) else $error("sent while host holds");

  property p_width_align;
    @(posedge core_clk) disable iff (!rst_n) wcmd |=> nib_hi && expect_lum;
  endproperty
  a_width_align: assert property (p_width_align) else $error("nibble phase not realigned");

  property p_status;
    @(posedge core_clk) disable iff (!rst_n)
      (bus_strobe && read_write_select && !reg_select_line && par_ok) |=> parallel_data_out == {$past(busy), $past(cursor)};
  endproperty
  a_status: assert property (p_status) else $error("status byte wrong");
endmodule : dmhi_top

// file: dv/dmhi_host_model.sv
// Host controller model driving the parallel and synchronous serial inputs of the display port
`timescale 1ns/1ps
module dmhi_host_model (
  input wire logic core_clk,
  input wire logic busy_out,
  input wire logic [7:0] parallel_data_out,
  output logic bus_strobe,
  output logic read_write_select,
  output logic reg_select_line,
  output logic [7:0] parallel_data_in,
  output logic serial_shift_clock,
  output logic serial_data_in,
  output logic serial_select_n,
  output logic stall_err
);
  // Idle bus: strobe low, shift clock still, select released
  initial begin
    bus_strobe = 1'b0;
    read_write_select = 1'b1;
    reg_select_line = 1'b0;
    parallel_data_in = 8'h00;
    serial_shift_clock = 1'b0;
    serial_data_in = 1'b1;
    serial_select_n = 1'b1;
    stall_err = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////////
  // Wait until the device reports ready before any byte
  task automatic wait_ready();
    int n;
    n = 0;
    while (busy_out !== 1'b0 && n < 20000) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 20000) stall_err <= 1'b1;
  endtask : wait_ready
  // One strobed write; select lines settle a cycle before the strobe rises
  task automatic strobe_out(input logic rs, input logic [7:0] val);
    @(posedge core_clk);
    read_write_select <= 1'b0;
    reg_select_line <= rs;
    parallel_data_in <= val;
    @(posedge core_clk);
    bus_strobe <= 1'b1;
    @(posedge core_clk);
    bus_strobe <= 1'b0;
    @(posedge core_clk);
    parallel_data_in <= ~val;
    repeat (3) @(posedge core_clk);
  endtask : strobe_out
  // Byte write, either whole or as high nibble then low nibble on the upper lines
  task automatic par_write(input logic rs, input logic [7:0] val, input logic w4, output logic mid_busy);
    wait_ready();
    mid_busy = 1'b0;
    if (w4) begin
      strobe_out(rs, {val[7:4], 4'h0});
      mid_busy = busy_out;
      strobe_out(rs, {val[3:0], 4'h0});
    end else begin
      strobe_out(rs, val);
    end
  endtask : par_write
  // Strobed read: data taken while the strobe is still high
  task automatic par_read(input logic rs, output logic [7:0] d);
    @(posedge core_clk);
    read_write_select <= 1'b1;
    reg_select_line <= rs;
    @(posedge core_clk);
    bus_strobe <= 1'b1;
    repeat (3) @(posedge core_clk);
    d = parallel_data_out;
    bus_strobe <= 1'b0;
  endtask : par_read
  // Serial frame of nbits, MSB first, data set while the shift clock is low
  task automatic ser_bits(input logic [7:0] val, input int nbits);
    wait_ready();
    serial_select_n <= 1'b0;
    for (int i = 7; i > 7 - nbits; i--) begin
      serial_data_in <= val[i];
      repeat (3) @(posedge core_clk);
      serial_shift_clock <= 1'b1;
      repeat (3) @(posedge core_clk);
      serial_shift_clock <= 1'b0;
    end
    repeat (2) @(posedge core_clk);
    serial_data_in <= ~serial_data_in;
    serial_select_n <= 1'b1;
    repeat (3) @(posedge core_clk);
  endtask : ser_bits
endmodule : dmhi_host_model

// file: dv/testbench.sv
// Self-checking bench for the display host port: APB, parallel and serial traffic
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin err_count++; \
  $display("FAIL %s expected %0h seen %0h", nm, ex, got); end end
module testbench;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic por_event = 1'b1;
  logic async_serial_sel = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic host_hold_line = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, bus_strobe, read_write_select, reg_select_line, parallel_data_oe_n, busy_out;
  logic serial_shift_clock, serial_data_in, serial_select_n, serial_data_out, module_busy_line, stall_err;
  logic [7:0] parallel_data_in, parallel_data_out;
  dmhi_pkg::dmhi_disp_t disp, last_disp;
  int err_count = 0;
  int n_checks = 0;
  int disp_cnt = 0;
  int exp_cnt = 0;
  logic sdo_low = 1'b0;
  logic [31:0] rd;
  logic er, mb;
  logic [7:0] pd;
  always #50 core_clk = ~core_clk;
  dmhi_top #(.POR_CYC(20), .HWR_CYC(10)) dut_u (.core_clk(core_clk), .rstn(rstn), .por_event(por_event),
    .async_serial_sel(async_serial_sel), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus_strobe(bus_strobe),
    .read_write_select(read_write_select), .reg_select_line(reg_select_line),
    .parallel_data_in(parallel_data_in), .parallel_data_out(parallel_data_out),
    .parallel_data_oe_n(parallel_data_oe_n), .busy_out(busy_out), .serial_shift_clock(serial_shift_clock),
    .serial_data_in(serial_data_in), .serial_select_n(serial_select_n), .host_hold_line(host_hold_line),
    .serial_data_out(serial_data_out), .module_busy_line(module_busy_line), .disp(disp));
  dmhi_host_model host_u (.core_clk(core_clk), .busy_out(busy_out), .parallel_data_out(parallel_data_out),
    .bus_strobe(bus_strobe), .read_write_select(read_write_select), .reg_select_line(reg_select_line),
    .parallel_data_in(parallel_data_in), .serial_shift_clock(serial_shift_clock),
    .serial_data_in(serial_data_in), .serial_select_n(serial_select_n), .stall_err(stall_err));
  // Capture each display byte and watch the serial output while the host holds
  always @(posedge core_clk) begin
    if (disp.valid === 1'b1) begin
      last_disp <= disp;
      disp_cnt <= disp_cnt + 1;
    end
    if (host_hold_line && serial_data_out !== 1'b1) sdo_low <= 1'b1;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  // One APB transfer: setup, access held until pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      err_count++;
      test_done();
    end
  endtask : apb
  // Reset pulse, then busy must clear after the init count
  task automatic do_reset(input logic por, input int lim);
    int n;
    @(posedge core_clk);
    rstn <= 1'b0;
    por_event <= por;
    repeat (12) @(posedge core_clk);
    rstn <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (busy_out !== 1'b0 && n < 100);
    `CHK("init busy", 1'b1, (n >= lim && n <= lim + 6))
  endtask : do_reset
  // Expect one new display byte
  task automatic chk_disp(input dmhi_pkg::dmhi_kind_t k, input logic [7:0] d, input logic [6:0] a);
    exp_cnt++;
    `CHK("disp count", exp_cnt, disp_cnt)
    `CHK("disp kind", k, last_disp.kind)
    `CHK("disp data", d, last_disp.data)
    `CHK("disp addr", a, last_disp.addr)
  endtask : chk_disp
  // Remaining busy time in cycles
  task automatic busy_len(input int lo, input int hi);
    int n;
    n = 0;
    while (busy_out === 1'b1 && n < 3000) begin
      @(posedge core_clk);
      n++;
    end
    `CHK("busy length", 1'b1, (n > lo && n <= hi))
  endtask : busy_len
  // Main sequence
  initial begin
    do_reset(1'b1, 20);
    apb(1'b0, 12'h000, 32'h0000_0000);
    `CHK("ctrl reset", 32'h0000_0003, rd)
    apb(1'b0, 12'h004, 32'h0000_0000);
    `CHK("stat reset", 15'h0000, {rd[15:13], rd[11:0]})
    apb(1'b1, 12'h0FC, 32'h0000_0003);
    `CHK("unmapped err", 1'b1, er)
    host_u.par_read(1'b0, pd);
    `CHK("status idle", 8'h00, pd)
    `CHK("read drive", 1'b0, parallel_data_oe_n)
    host_u.par_write(1'b1, 8'h41, 1'b0, mb);
    chk_disp(dmhi_pkg::DMHI_K_TEXT, 8'h41, 7'h00);
    host_u.par_read(1'b0, pd);
    `CHK("status busy", 8'h81, pd)
    `CHK("busy line", 1'b1, module_busy_line)
    busy_len(300, 400);
    host_u.par_write(1'b1, 8'h0A, 1'b0, mb);
    chk_disp(dmhi_pkg::DMHI_K_GLYPH, 8'h02, 7'h01);
    host_u.par_write(1'b1, 8'h02, 1'b0, mb);
    chk_disp(dmhi_pkg::DMHI_K_GLYPH, 8'h02, 7'h02);
    host_u.par_write(1'b0, 8'h20, 1'b0, mb);
    chk_disp(dmhi_pkg::DMHI_K_CMD, 8'h20, 7'h03);
    host_u.par_write(1'b1, 8'h02, 1'b1, mb);
    apb(1'b0, 12'h004, 32'h0000_0000);
    `CHK("bright width", 3'h6, rd[10:8])
    host_u.par_write(1'b1, 8'h55, 1'b1, mb);
    `CHK("nibble busy", 1'b0, mb)
    chk_disp(dmhi_pkg::DMHI_K_TEXT, 8'h55, 7'h03);
    host_u.par_write(1'b0, 8'hF0, 1'b1, mb);
    chk_disp(dmhi_pkg::DMHI_K_CMD, 8'hF0, 7'h04);
    host_u.par_write(1'b1, 8'h42, 1'b1, mb);
    chk_disp(dmhi_pkg::DMHI_K_GFX, 8'h42, 7'h04);
    busy_len(2400, 2500);
    host_u.par_write(1'b0, 8'hEF, 1'b1, mb);
    chk_disp(dmhi_pkg::DMHI_K_CMD, 8'hEF, 7'h04);
    host_u.par_write(1'b1, 8'h61, 1'b1, mb);
    chk_disp(dmhi_pkg::DMHI_K_TEXT, 8'h61, 7'h6F);
    host_u.par_write(1'b1, 8'h62, 1'b1, mb);
    chk_disp(dmhi_pkg::DMHI_K_EXT, 8'h62, 7'h70);
    async_serial_sel <= 1'b1;
    do_reset(1'b0, 10);
    apb(1'b0, 12'h004, 32'h0000_0000);
    `CHK("stat after reset", 8'h10, {rd[15:12], rd[10], rd[2:0]})
    host_u.ser_bits(8'hA0, 3);
    host_u.ser_bits(8'h48, 8);
    chk_disp(dmhi_pkg::DMHI_K_TEXT, 8'h48, 7'h00);
    apb(1'b1, 12'h008, 32'h0000_005A);
    host_hold_line <= 1'b1;
    host_u.ser_bits(8'h0F, 8);
    `CHK("prefix swallowed", exp_cnt, disp_cnt)
    host_u.ser_bits(8'h01, 8);
    chk_disp(dmhi_pkg::DMHI_K_CMD, 8'h01, 7'h01);
    apb(1'b0, 12'h004, 32'h0000_0000);
    `CHK("tx held", 2'h3, {rd[15], rd[14]})
    `CHK("sdo idle", 1'b0, sdo_low)
    host_hold_line <= 1'b0;
    host_u.par_write(1'b1, 8'h43, 1'b0, mb);
    `CHK("parallel locked", exp_cnt, disp_cnt)
    `CHK("host stall", 1'b0, stall_err)
    test_done();
  end
  // Watchdog for a hung run
  initial begin
    #5000000;
    err_count++;
    test_done();
  end
endmodule : testbench
